// >>> design/boundary_scan_order_ctrl_defines.svh
`ifndef BOUNDARY_SCAN_ORDER_CTRL_DEFINES_SVH
`define BOUNDARY_SCAN_ORDER_CTRL_DEFINES_SVH

// register word indices; byte address is four times the index
`define IDX_MCU_CONTROL     8'h35
`define IDX_RESET_STATUS    8'h36
`define IDX_IRQ_STATUS      8'h38
`define IDX_IRQ_CLEAR       8'h39
`define IDX_IRQ_ENABLE      8'h3A

`define MCU_CONTROL_RESET   8'h00
`define MCU_CONTROL_RW_MASK 8'h93
`define BIT_TEST_PORT_DIS   7
`define BIT_PULLUP_DIS      4
`define BIT_VECTOR_SEL      1
`define BIT_VECTOR_CHG      0
`define BIT_TEST_PORT_RST   4

`define IRQ_BIT_TEST_RESET  0
`define IRQ_BIT_DIS_CHANGED 1
`define IRQ_BIT_DIS_EXPIRED 2
`define IRQ_WIDTH           3

`define TIMED_WINDOW        3'h4

`define CHAIN_LEN           57
`define CELL_RESET_OBSERVE  40

`define INSTR_EXTEST        4'h0
`define INSTR_IDCODE        4'h1
`define INSTR_SAMPLE        4'h2
`define INSTR_CHIP_RESET    4'hC
`define INSTR_BYPASS        4'hF
`define IR_CAPTURE_VALUE    4'h1

`endif

// >>> design/boundary_scan_order_pkg.sv
package boundary_scan_order_pkg;

  typedef enum logic [3:0] {
    st_reset     = 4'h0,
    st_idle      = 4'h1,
    st_sel_dr    = 4'h2,
    st_cap_dr    = 4'h3,
    st_shift_dr  = 4'h4,
    st_exit1_dr  = 4'h5,
    st_pause_dr  = 4'h6,
    st_exit2_dr  = 4'h7,
    st_upd_dr    = 4'h8,
    st_sel_ir    = 4'h9,
    st_cap_ir    = 4'hA,
    st_shift_ir  = 4'hB,
    st_exit1_ir  = 4'hC,
    st_pause_ir  = 4'hD,
    st_exit2_ir  = 4'hE,
    st_upd_ir    = 4'hF
  } tap_state_type;

  typedef struct packed {
    logic [7:0] d;
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } port_set_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic fuse;
    logic reset_pin;
  } link_in_type;

endpackage : boundary_scan_order_pkg

// >>> design/boundary_scan_order_ctrl.sv
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`include "boundary_scan_order_ctrl_defines.svh"

// Function
// R01 - chain shifts LSB first; cell 0 enters first from tdi, leaves first on tdo
// R02 - boundary chain is cells 0..56, port A pin 0 at 0, port B pin 0 at 56
// R03 - from top: port B 0..7, reset observe, port D 0..7, port C, port A 7..0
// R04 - port A cells run with descending pin index toward the low end
// R05 - each pin pair: data cell above, its output-control cell directly below
// R06 - cell 40 only observes the reset pin level, never drives it
// R07 - analog interface cells would sit at the top end; this device has none
// R08 - the four test access pins have no cells in the chain
// R09 - control bit 7 disables the test port; zero enables it if fuse is set
// R10 - bit 7 changes only after the same value is written twice within four cycles
// R11 - software keeps bit 7 unchanged while on-chip debug is in use
// R12 - control resets to zero; bits 7,4,1,0 writable, others read zero
// R13 - status bit 4 sets whenever the test reset register forces reset
// R14 - status flag cleared by power-on reset or writing zero; writing one keeps it
// R15 - chip reset instruction selects one-bit unlatched reset register holding reset
// R16 - capture with extest or sample loads external pin levels into the chain
// R17 - unmatched first write to bit 7 expires after four cycles, keeping old value
// R18 - port C cells: 0 data/ctrl, 1 data/ctrl, 2 data, 6 data/ctrl, 7 data/ctrl
module boundary_scan_order_ctrl #(
  parameter logic [31:0] IDCODE_VALUE = 32'h0000_0001  // arbitrary identity value
) (
  input  wire  logic                               clk,
  input  wire  logic                               resetn,
  input  wire  logic [7:0]                         address,
  input  wire  logic                               read,
  input  wire  logic                               write,
  input  wire  logic [31:0]                        writedata,
  input  wire  logic [3:0]                         byteenable,
  output logic [31:0]                              readdata,
  output logic                                     waitrequest,
  output logic                                     irq,
  input  wire  boundary_scan_order_pkg::link_in_type link_in,
  output logic                                     tdo,
  input  wire  boundary_scan_order_pkg::port_set_type pin_level,
  input  wire  boundary_scan_order_pkg::port_set_type core_value,
  input  wire  boundary_scan_order_pkg::port_set_type core_enable,
  output boundary_scan_order_pkg::port_set_type    pin_value,
  output boundary_scan_order_pkg::port_set_type    pin_enable,
  output logic                                     chip_reset,
  output logic                                     test_port_active,
  output logic [7:0]                               mcu_control
);

  boundary_scan_order_pkg::link_in_type  link_s1_ff, link_s2_ff;
  boundary_scan_order_pkg::port_set_type pin_s1_ff, pin_s2_ff;
  boundary_scan_order_pkg::port_set_type nxt_pin_value, nxt_pin_enable;
  boundary_scan_order_pkg::port_set_type pin_value_ff, pin_enable_ff;
  boundary_scan_order_pkg::tap_state_type tap_ff, nxt_tap;
  logic                   tck_prev_ff;
  logic                   tck_rise, tck_fall;
  logic [3:0]             ir_ff, ir_shift_ff;
  logic [`CHAIN_LEN-1:0]  bsr_ff, bsr_latch_ff, nxt_capture;
  logic [31:0]            id_ff;
  logic                   bypass_ff, reset_reg_ff, reset_reg_prev_ff, tdo_ff, port_active_ff;
  logic                   scan_sel, active;
  logic [7:0]             mcu_control_ff, status_ff;
  logic                   pend_ff, pend_val_ff;
  logic [2:0]             window_ff;
  logic                   waitrequest_ff, irq_ff;
  logic [31:0]            readdata_ff;
  logic [`IRQ_WIDTH-1:0]  irq_status_ff, irq_enable_ff, nxt_events;
  logic                   acc, wr_ctrl, wr_stat, commit, start, expire;

  // pins and the test clock come from outside: two flops before any use
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_s1_ff  <= '0;
      link_s2_ff  <= '0;
      pin_s1_ff   <= '0;
      pin_s2_ff   <= '0;
      tck_prev_ff <= 1'b0;
    end else begin
      link_s1_ff  <= link_in;
      link_s2_ff  <= link_s1_ff;
      pin_s1_ff   <= pin_level;
      pin_s2_ff   <= pin_s1_ff;
      tck_prev_ff <= link_s2_ff.tck;
    end
  end

  assign tck_rise = link_s2_ff.tck & ~tck_prev_ff;
  assign tck_fall = ~link_s2_ff.tck & tck_prev_ff;
  assign active   = link_s2_ff.fuse & ~mcu_control_ff[`BIT_TEST_PORT_DIS];  // [R09]
  assign scan_sel = (ir_ff == `INSTR_EXTEST) || (ir_ff == `INSTR_SAMPLE);

  always_comb begin
    case (tap_ff)
      boundary_scan_order_pkg::st_reset:
        nxt_tap = link_s2_ff.tms ? boundary_scan_order_pkg::st_reset
                                 : boundary_scan_order_pkg::st_idle;
      boundary_scan_order_pkg::st_idle, boundary_scan_order_pkg::st_upd_dr,
      boundary_scan_order_pkg::st_upd_ir:
        nxt_tap = link_s2_ff.tms ? boundary_scan_order_pkg::st_sel_dr
                                 : boundary_scan_order_pkg::st_idle;
      boundary_scan_order_pkg::st_sel_dr:
        nxt_tap = link_s2_ff.tms ? boundary_scan_order_pkg::st_sel_ir
                                 : boundary_scan_order_pkg::st_cap_dr;
      boundary_scan_order_pkg::st_cap_dr, boundary_scan_order_pkg::st_shift_dr,
      boundary_scan_order_pkg::st_exit2_dr:
        nxt_tap = link_s2_ff.tms ? boundary_scan_order_pkg::st_exit1_dr
                                 : boundary_scan_order_pkg::st_shift_dr;
      boundary_scan_order_pkg::st_exit1_dr:
        nxt_tap = link_s2_ff.tms ? boundary_scan_order_pkg::st_upd_dr
                                 : boundary_scan_order_pkg::st_pause_dr;
      boundary_scan_order_pkg::st_pause_dr:
        nxt_tap = link_s2_ff.tms ? boundary_scan_order_pkg::st_exit2_dr
                                 : boundary_scan_order_pkg::st_pause_dr;
      boundary_scan_order_pkg::st_sel_ir:
        nxt_tap = link_s2_ff.tms ? boundary_scan_order_pkg::st_reset
                                 : boundary_scan_order_pkg::st_cap_ir;
      boundary_scan_order_pkg::st_cap_ir, boundary_scan_order_pkg::st_shift_ir,
      boundary_scan_order_pkg::st_exit2_ir:
        nxt_tap = link_s2_ff.tms ? boundary_scan_order_pkg::st_exit1_ir
                                 : boundary_scan_order_pkg::st_shift_ir;
      boundary_scan_order_pkg::st_exit1_ir:
        nxt_tap = link_s2_ff.tms ? boundary_scan_order_pkg::st_upd_ir
                                 : boundary_scan_order_pkg::st_pause_ir;
      boundary_scan_order_pkg::st_pause_ir:
        nxt_tap = link_s2_ff.tms ? boundary_scan_order_pkg::st_exit2_ir
                                 : boundary_scan_order_pkg::st_pause_ir;
      default:
        nxt_tap = boundary_scan_order_pkg::st_reset;
    endcase
  end

  // a disabled port holds the controller in its reset state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tap_ff <= boundary_scan_order_pkg::st_reset;
    end else if (!active) begin
      tap_ff <= boundary_scan_order_pkg::st_reset;  // [R09]
    end else if (tck_rise) begin
      tap_ff <= nxt_tap;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ir_shift_ff <= '0;
      ir_ff       <= `INSTR_IDCODE;
    end else if (tap_ff == boundary_scan_order_pkg::st_reset) begin
      ir_ff <= `INSTR_IDCODE;
    end else if (tck_rise) begin
      case (tap_ff)
        boundary_scan_order_pkg::st_cap_ir:   ir_shift_ff <= `IR_CAPTURE_VALUE;
        boundary_scan_order_pkg::st_shift_ir: ir_shift_ff <= {link_s2_ff.tdi, ir_shift_ff[3:1]};
        boundary_scan_order_pkg::st_upd_ir:   ir_ff <= ir_shift_ff;
        default:                              ir_ff <= ir_ff;
      endcase
    end
  end

  // chain layout; C3..C5 (test access pins) have no cells, C2 and A0 are data only
  always_comb begin
    nxt_capture = '0;
    for (int i = 0; i < 8; i++) begin
      nxt_capture[56-2*i] = pin_s2_ff.b[i];    // [R02] [R03] [R05]
      nxt_capture[55-2*i] = core_enable.b[i];  // [R05]
      nxt_capture[39-2*i] = pin_s2_ff.d[i];    // [R03]
      nxt_capture[38-2*i] = core_enable.d[i];
      nxt_capture[2*i]    = pin_s2_ff.a[i];    // [R04]
      if (i > 0) begin
        nxt_capture[2*i-1] = core_enable.a[i];
      end
    end
    nxt_capture[`CELL_RESET_OBSERVE] = link_s2_ff.reset_pin;  // [R06]
    nxt_capture[23] = pin_s2_ff.c[0];  // [R18] [R08]
    nxt_capture[22] = core_enable.c[0];
    nxt_capture[21] = pin_s2_ff.c[1];
    nxt_capture[20] = core_enable.c[1];
    nxt_capture[19] = pin_s2_ff.c[2];
    nxt_capture[18] = pin_s2_ff.c[6];
    nxt_capture[17] = core_enable.c[6];
    nxt_capture[16] = pin_s2_ff.c[7];
    nxt_capture[15] = core_enable.c[7];
  end

  // data registers; analog cells would append at the top, none exist here [R07]
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bsr_ff       <= '0;
      bsr_latch_ff <= '0;
      id_ff        <= '0;
      bypass_ff    <= 1'b0;
      reset_reg_ff <= 1'b0;
    end else if (tck_rise && tap_ff == boundary_scan_order_pkg::st_cap_dr) begin
      if (scan_sel) begin
        bsr_ff <= nxt_capture;  // [R16]
      end
      id_ff     <= IDCODE_VALUE;
      bypass_ff <= 1'b0;
    end else if (tck_rise && tap_ff == boundary_scan_order_pkg::st_shift_dr) begin
      if (scan_sel) begin
        bsr_ff <= {link_s2_ff.tdi, bsr_ff[`CHAIN_LEN-1:1]};  // [R01]
      end
      if (ir_ff == `INSTR_CHIP_RESET) begin
        reset_reg_ff <= link_s2_ff.tdi;  // [R15]
      end
      id_ff     <= {link_s2_ff.tdi, id_ff[31:1]};
      bypass_ff <= link_s2_ff.tdi;
    end else if (tck_rise && tap_ff == boundary_scan_order_pkg::st_upd_dr && scan_sel) begin
      bsr_latch_ff <= bsr_ff;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tdo_ff <= 1'b0;
    end else if (tck_fall) begin
      case (ir_ff)
        `INSTR_EXTEST, `INSTR_SAMPLE: tdo_ff <= bsr_ff[0];  // [R01]
        `INSTR_IDCODE:                tdo_ff <= id_ff[0];
        `INSTR_CHIP_RESET:            tdo_ff <= reset_reg_ff;
        default:                      tdo_ff <= bypass_ff;
      endcase
    end
  end

  // extest drives pins from the update latch; cell 40 has no drive path [R06]
  always_comb begin
    nxt_pin_value  = core_value;
    nxt_pin_enable = core_enable;
    if (ir_ff == `INSTR_EXTEST) begin
      nxt_pin_enable = '0;
      for (int i = 0; i < 8; i++) begin
        nxt_pin_value.b[i]  = bsr_latch_ff[56-2*i];
        nxt_pin_enable.b[i] = bsr_latch_ff[55-2*i];
        nxt_pin_value.d[i]  = bsr_latch_ff[39-2*i];
        nxt_pin_enable.d[i] = bsr_latch_ff[38-2*i];
        nxt_pin_value.a[i]  = bsr_latch_ff[2*i];
        if (i > 0) begin
          nxt_pin_enable.a[i] = bsr_latch_ff[2*i-1];
        end
      end
      nxt_pin_value.c  = {bsr_latch_ff[16], bsr_latch_ff[18], core_value.c[5:3],
                          bsr_latch_ff[19], bsr_latch_ff[21], bsr_latch_ff[23]};
      nxt_pin_enable.c = {bsr_latch_ff[15], bsr_latch_ff[17], 3'h0, 1'b0,
                          bsr_latch_ff[20], bsr_latch_ff[22]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_value_ff  <= '0;
      pin_enable_ff <= '0;
    end else begin
      pin_value_ff  <= nxt_pin_value;
      pin_enable_ff <= nxt_pin_enable;
    end
  end

  // every access answers on the second edge, so back-to-back writes land 2 cycles apart
  assign acc     = (read | write) & ~waitrequest_ff;
  assign wr_ctrl = acc & write & byteenable[0] & (address == `IDX_MCU_CONTROL);
  assign wr_stat = acc & write & byteenable[0] & (address == `IDX_RESET_STATUS);
  assign commit  = wr_ctrl & pend_ff & (writedata[`BIT_TEST_PORT_DIS] == pend_val_ff);
  assign start   = wr_ctrl & ~commit;
  assign expire  = pend_ff & (window_ff == 3'h1) & ~wr_ctrl;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitrequest_ff <= 1'b1;
    end else begin
      waitrequest_ff <= ~((read | write) & waitrequest_ff);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_ff     <= 1'b0;
      pend_val_ff <= 1'b0;
      window_ff   <= 3'h0;
    end else if (start) begin
      pend_ff     <= 1'b1;  // [R10]
      pend_val_ff <= writedata[`BIT_TEST_PORT_DIS];
      window_ff   <= `TIMED_WINDOW;
    end else begin
      if (commit || expire) begin
        pend_ff <= 1'b0;  // [R17]
      end
      if (window_ff != 3'h0) begin
        window_ff <= window_ff - 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mcu_control_ff <= `MCU_CONTROL_RESET;  // [R12]
    end else if (wr_ctrl) begin
      mcu_control_ff[`BIT_PULLUP_DIS] <= writedata[`BIT_PULLUP_DIS];  // [R12]
      mcu_control_ff[`BIT_VECTOR_SEL] <= writedata[`BIT_VECTOR_SEL];
      mcu_control_ff[`BIT_VECTOR_CHG] <= writedata[`BIT_VECTOR_CHG];
      if (commit) begin
        mcu_control_ff[`BIT_TEST_PORT_DIS] <= pend_val_ff;  // [R10]
      end
    end
  end

  // a pending forced reset outweighs a software clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_ff <= 8'h00;  // [R14]
    end else if (reset_reg_ff) begin
      status_ff[`BIT_TEST_PORT_RST] <= 1'b1;  // [R13]
    end else if (wr_stat && !writedata[`BIT_TEST_PORT_RST]) begin
      status_ff[`BIT_TEST_PORT_RST] <= 1'b0;  // [R14]
    end
  end

  always_comb begin
    nxt_events = '0;
    // rising edge only: a level would re-set the flag after every clear
    nxt_events[`IRQ_BIT_TEST_RESET]  = reset_reg_ff & ~reset_reg_prev_ff;
    nxt_events[`IRQ_BIT_DIS_CHANGED] = commit & (pend_val_ff != mcu_control_ff[7]);
    nxt_events[`IRQ_BIT_DIS_EXPIRED] = expire;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_status_ff     <= '0;
      irq_enable_ff     <= '0;
      irq_ff            <= 1'b0;
      reset_reg_prev_ff <= 1'b0;
    end else begin
      reset_reg_prev_ff <= reset_reg_ff;
      if (acc && write && byteenable[0] && address == `IDX_IRQ_CLEAR) begin
        irq_status_ff <= (irq_status_ff & ~writedata[`IRQ_WIDTH-1:0]) | nxt_events;
      end else begin
        irq_status_ff <= irq_status_ff | nxt_events;
      end
      if (acc && write && byteenable[0] && address == `IDX_IRQ_ENABLE) begin
        irq_enable_ff <= writedata[`IRQ_WIDTH-1:0];
      end
      irq_ff <= |(irq_status_ff & irq_enable_ff);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readdata_ff <= '0;
    end else if (read && waitrequest_ff) begin
      case (address)
        `IDX_MCU_CONTROL:  readdata_ff <= {24'h0, mcu_control_ff};
        `IDX_RESET_STATUS: readdata_ff <= {24'h0, status_ff};
        `IDX_IRQ_STATUS:   readdata_ff <= {29'h0, irq_status_ff};
        `IDX_IRQ_ENABLE:   readdata_ff <= {29'h0, irq_enable_ff};
        default:           readdata_ff <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_active_ff <= 1'b0;
    end else begin
      port_active_ff <= active & (tap_ff != boundary_scan_order_pkg::st_reset);  // [R09]
    end
  end

  assign readdata         = readdata_ff;
  assign waitrequest      = waitrequest_ff;
  assign irq              = irq_ff;
  assign tdo              = tdo_ff;
  assign pin_value        = pin_value_ff;
  assign pin_enable       = pin_enable_ff;
  assign chip_reset       = reset_reg_ff;  // [R15]
  assign test_port_active = port_active_ff;
  assign mcu_control      = mcu_control_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence seq_first_write;
    start;
  endsequence
  sequence seq_matching_write;
    commit;
  endsequence

  a_timed_commit: assert property (commit |=> mcu_control_ff[7] == $past(pend_val_ff)) // [R10]
    else $error("timed double write did not set disable bit");
  a_pair_window: assert property (seq_first_write ##[1:4] seq_matching_write
                                  |=> mcu_control_ff[7] == $past(writedata[7])) // [R10]
    else $error("disable bit wrong after matched pair");
  a_single_hold: assert property (start |=> $stable(mcu_control_ff[7])) // [R10]
    else $error("single write changed disable bit");
  a_window_expire: assert property (start ##1 (!wr_ctrl)[*4] |=> !pend_ff) // [R17]
    else $error("pending change outlived four cycles");
  a_reserved_zero: assert property ((mcu_control_ff & ~`MCU_CONTROL_RW_MASK) == 8'h00) // [R12]
    else $error("reserved control bits not zero");
  a_flag_set: assert property (reset_reg_ff |=> status_ff[4]) // [R13]
    else $error("test reset flag not set");
  a_flag_keep: assert property (wr_stat && writedata[4] && !reset_reg_ff // [R14]
                                |=> status_ff[4] == $past(status_ff[4]))
    else $error("writing one altered the flag");
  a_capture_order: assert property (tck_rise && tap_ff == boundary_scan_order_pkg::st_cap_dr
      && scan_sel |=> bsr_ff[56] == $past(pin_s2_ff.b[0]) && bsr_ff[0] == $past(pin_s2_ff.a[0])
      && bsr_ff[40] == $past(link_s2_ff.reset_pin) && bsr_ff[14] == $past(pin_s2_ff.a[7])) // [R02]
    else $error("capture cell order wrong");
  a_tdo_lsb: assert property (tck_fall && scan_sel |=> tdo_ff == $past(bsr_ff[0])) // [R01]
    else $error("tdo does not carry cell zero");
  a_port_disabled: assert property (!active // [R09]
                                    |=> tap_ff == boundary_scan_order_pkg::st_reset)
    else $error("disabled test port left reset state");

endmodule : boundary_scan_order_ctrl

// >>> sim/scan_tester_model.sv
`timescale 1ns/1ps
// far-side scan tester: tck stands low between frames, four core clocks per half period
module scan_tester_model (
  input  wire logic clk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one test clock period; tdo is taken mid-high, well after the design's sync latency
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (2) @(posedge clk);
    q = tdo;
    repeat (2) @(posedge clk);
    tck <= 1'b0;
  endtask : step

  task automatic tap_reset;
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : tap_reset

  // from idle: select, capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic is_ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (is_ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], q);
      dout[k] = q;
    end
    step(1'b1, 1'b0, q);
    // tdi no longer meaningful: show the inverse of the last bit
    step(1'b0, ~din[n-1], q);
  endtask : scan
endmodule : scan_tester_model

// >>> sim/test_boundary_scan_order_ctrl.sv
`timescale 1ns/1ps
module test_boundary_scan_order_ctrl;
  logic                                 clk, resetn, read, write, irq, tdo, waitrequest;
  logic                                 tck, tms, tdi, fuse, reset_pin, chip_reset;
  logic                                 test_port_active;
  logic [7:0]                           address, mcu_control;
  logic [31:0]                          writedata, readdata, q;
  logic [3:0]                           byteenable;
  logic [63:0]                          dout;
  boundary_scan_order_pkg::link_in_type  link_in;
  boundary_scan_order_pkg::port_set_type pin_level, core_value, core_enable;
  boundary_scan_order_pkg::port_set_type pin_value, pin_enable;
  int                                   num_errors, compares, cycles;

  assign link_in = {tck, tms, tdi, fuse, reset_pin};

  boundary_scan_order_ctrl uut (.clk(clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .link_in(link_in), .tdo(tdo),
    .pin_level(pin_level), .core_value(core_value), .core_enable(core_enable),
    .pin_value(pin_value), .pin_enable(pin_enable), .chip_reset(chip_reset),
    .test_port_active(test_port_active), .mcu_control(mcu_control));

  scan_tester_model tester (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // entered just after a rising edge; the request stands until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    read      <= ~w;
    write     <= w;
    address   <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
  endtask : bus

  task automatic idle(input int n);
    read  <= 1'b0;
    write <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  function automatic logic [56:0] chain(boundary_scan_order_pkg::port_set_type pl,
                                        boundary_scan_order_pkg::port_set_type ce, logic rp);
    logic [56:0] e;
    e = '0;
    for (int i = 0; i < 8; i++) begin
      e[56-2*i] = pl.b[i];
      e[55-2*i] = ce.b[i];
      e[39-2*i] = pl.d[i];
      e[38-2*i] = ce.d[i];
      if (i > 0) e[2*i] = pl.a[i];
      if (i > 0) e[2*i-1] = ce.a[i];
    end
    e[40] = rp;
    e[0] = pl.a[0];
    {e[23], e[22], e[21], e[20], e[19]} = {pl.c[0], ce.c[0], pl.c[1], ce.c[1], pl.c[2]};
    {e[18], e[17], e[16], e[15]} = {pl.c[6], ce.c[6], pl.c[7], ce.c[7]};
    return e;
  endfunction : chain

  initial begin
    {num_errors, compares, cycles} = '0;
    {resetn, read, write, address, writedata} = '0;
    byteenable  = 4'h1;
    fuse        = 1'b1;
    reset_pin   = 1'b1;
    pin_level   = 32'h5A3C_C396;
    core_value  = 32'h1248_8421;
    core_enable = 32'h0FF0_33CC;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b0, 8'h35, 32'h0);
    chk(q, 64'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk(q, 64'h0);
    chk(pin_value, core_value);
    $display("test reset_values done");
    // a lone write to the disable bit must lapse; the other writable bits take at once
    bus(1'b1, 8'h35, 32'hFF);
    idle(8);
    bus(1'b0, 8'h35, 32'h0);
    chk(q, 64'h13);
    chk(mcu_control, 64'h13);
    bus(1'b1, 8'h35, 32'h80);
    bus(1'b1, 8'h35, 32'h80);
    idle(1);
    bus(1'b0, 8'h35, 32'h0);
    chk(q, 64'h80);
    tester.tap_reset();
    idle(1);
    chk(test_port_active, 64'h0);
    bus(1'b1, 8'h35, 32'h0);
    bus(1'b1, 8'h35, 32'h0);
    idle(1);
    tester.tap_reset();
    idle(1);
    chk(test_port_active, 64'h1);
    $display("test timed_disable done");
    bus(1'b0, 8'h38, 32'h0);
    chk(q, 64'h6);
    chk(irq, 64'h0);
    bus(1'b1, 8'h3A, 32'h4);
    idle(3);
    chk(irq, 64'h1);
    bus(1'b1, 8'h39, 32'h7);
    bus(1'b0, 8'h38, 32'h0);
    chk(q, 64'h0);
    bus(1'b0, 8'h39, 32'h0);
    chk(q, 64'h0);
    idle(3);
    chk(irq, 64'h0);
    $display("test interrupts done");
    // the test reset register only - on-chip debug is never in use here
    tester.scan(1'b1, 4, 64'hC, dout);
    tester.scan(1'b0, 1, 64'h1, dout);
    chk(chip_reset, 64'h1);
    bus(1'b0, 8'h36, 32'h0);
    chk(q & 32'h10, 64'h10);
    bus(1'b0, 8'h38, 32'h0);
    chk(q & 32'h1, 64'h1);
    tester.scan(1'b0, 1, 64'h0, dout);
    chk(chip_reset, 64'h0);
    bus(1'b1, 8'h36, 32'hFF);
    bus(1'b0, 8'h36, 32'h0);
    chk(q & 32'h10, 64'h10);
    bus(1'b1, 8'h36, 32'h0);
    bus(1'b0, 8'h36, 32'h0);
    chk(q & 32'h10, 64'h0);
    idle(1);
    $display("test chip_reset done");
    // one extra shift proves the chain length: the first tdi bit shows up after 57 cells
    tester.scan(1'b1, 4, 64'h2, dout);
    tester.scan(1'b0, 58, 64'h1, dout);
    chk(dout[56:0], chain(pin_level, core_enable, reset_pin));
    chk(dout[57], 64'h1);
    reset_pin <= 1'b0;
    pin_level <= ~pin_level;
    tester.scan(1'b0, 57, 64'h0, dout);
    chk(dout[56:0], chain(pin_level, core_enable, 1'b0));
    $display("test scan_order done");
    // a port reset brings back the identity register as the default data path
    tester.tap_reset();
    tester.scan(1'b0, 32, 64'h0, dout);
    chk(dout[31:0], uut.IDCODE_VALUE);
    tester.scan(1'b1, 4, 64'hF, dout);
    tester.scan(1'b0, 2, 64'h1, dout);
    chk(dout[1:0], 64'h2);
    // all-ones latch drives every pin with a control cell; PC3..PC5 keep the core value but are not driven
    tester.scan(1'b1, 4, 64'h0, dout);
    tester.scan(1'b0, 57, 64'h01FF_FFFF_FFFF_FFFF, dout);
    idle(2);
    chk(pin_value, 64'hFFCF_FFFF);
    chk(pin_enable, 64'hFFC3_FFFE);
    $display("test extest_drive done");
    tally_and_finish();
  end
endmodule : test_boundary_scan_order_ctrl
